// [cmc_defs.svh]
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

// Gear codes: divide the high-speed clock by 1, 2, 4 or 8
`define CMC_GEAR_DIV1 2'h0
// Countdown loaded by a gear write; the new gear is applied five cycles after the write
`define CMC_GEAR_DELAY 3'h4
// Clock output selections
`define CMC_SCO_LS 2'h0
`define CMC_SCO_SYS2 2'h1
`define CMC_SCO_SYS 2'h2
`define CMC_SCO_PRE 2'h3
// Low-power request codes
`define CMC_LP_RUN 2'h0
`define CMC_LP_IDLE 2'h1
`define CMC_LP_SLEEP 2'h2
`define CMC_LP_STOP 2'h3
// Warm-up: zero selection means no count, high-speed exponent base
`define CMC_WU_NONE 3'h0
`define CMC_WU_HS_BASE 5'h09
// Low-speed warm-up exponents for selections 1 to 7
`define CMC_WU_LS1 5'h06
`define CMC_WU_LS2 5'h07
`define CMC_WU_LS3 5'h08
`define CMC_WU_LS4 5'h0F
`define CMC_WU_LS5 5'h10
`define CMC_WU_LS6 5'h11
`define CMC_WU_LS7 5'h12
// Low-speed exponents packed by selection; entry zero is never counted
`define CMC_WU_LS_TABLE {`CMC_WU_LS7, `CMC_WU_LS6, `CMC_WU_LS5, `CMC_WU_LS4, \
    `CMC_WU_LS3, `CMC_WU_LS2, `CMC_WU_LS1, 5'h00}
// Prescaler divide code for the undivided source
`define CMC_PRE_DIV1 3'h0

`endif

// [cmc_pkg.sv]
package cmc_pkg;
    // Operating mode, derived from the clock actually driving the system
    typedef enum logic {CMC_NORMAL, CMC_SLOW} cmc_mode_e;
    // Warm-up counter word
    typedef logic [18:0] cmc_wu_t;
endpackage

// [cmc_clock_mode_ctrl.sv]
`timescale 1ns/1ps
`include "cmc_defs.svh"

// Summary of operation
// - Start pulse runs warm-up on chosen source
// - Warm-up status high while counting
// - Select 1 low-speed, 0 geared high-speed
// - Status flips only after switch completes
// - Gear divides by 1/2/4/8, reset one
// - Gear change applied after short delay
// - Prescaler divides peripheral source, reset undivided
// - Output select routes four clocks
// - Output held static in low-power modes, except the low-speed selection
// - Pin drives only when direction and function
// - NORMAL high-speed, SLOW low-speed system clock
// - Reset enters NORMAL on high-speed clock
// - SLOW stops high-speed peripherals
// - Core clock halted in low-power modes
// - PLL off after reset until enabled
// - Status 0 high-speed, 1 low-speed
module cmc_clock_mode_ctrl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic high_speed_clock,
    input wire logic low_speed_clock,
    input wire logic hs_osc_enable,
    input wire logic ls_osc_enable,
    input wire logic pll_enable_bit,
    input wire logic warmup_source_select,
    input wire logic [2:0] warmup_time_field,
    input wire logic warmup_start_bit,
    input wire logic system_clock_select_bit,
    input wire logic [1:0] gear_field,
    input wire logic gear_write,
    input wire logic peripheral_source_select,
    input wire logic [2:0] prescaler_divide_field,
    input wire logic [1:0] clock_output_select,
    input wire logic port_k1_direction_bit,
    input wire logic port_k1_function_bit,
    input wire logic [1:0] low_power_mode,
    output logic warmup_status_bit,
    output logic system_clock_status_bit,
    output logic system_clock,
    output logic prescaler_base_clock,
    output logic clock_output_pin,
    output logic clock_output_oe,
    output logic core_clock_enable,
    output logic periph_clock_enable,
    output logic pll_active,
    output logic slow_mode,
    output logic [1:0] gear_active
);
    // Pin synchronisers; stage 0 is read only by stage 1
    logic [1:0] hs_sync_reg, ls_sync_reg;
    logic hs_prev_reg, ls_prev_reg;
    // Clock path state
    logic [1:0] gear_reg, gear_next, gear_pend_reg, gear_pend_next;
    logic [2:0] gear_dly_reg, gear_dly_next;
    logic [2:0] gdiv_reg, gdiv_next;
    logic [4:0] pdiv_reg, pdiv_next;
    logic sys_clk_reg, sys_clk_next, sys2_reg, sys2_next;
    logic pre_clk_reg, pre_clk_next, ls_lvl_reg, ls_lvl_next, status_reg, status_next;
    cmc_pkg::cmc_mode_e mode_reg, mode_next;
    // Warm-up state
    logic wu_busy_reg, wu_busy_next;
    cmc_pkg::cmc_wu_t wu_cnt_reg, wu_cnt_next, wu_lim_reg, wu_lim_next;
    logic wu_src_reg, wu_src_next;
    // Output pin and mode flags
    logic sco_reg, sco_next, sco_oe_reg, sco_oe_next;
    logic core_en_reg, core_en_next, per_en_reg, per_en_next, pll_reg, pll_next;
    // Combinational ticks: one per half period of each clock
    logic hs_run, ls_run, hs_tick, ls_tick, hs_rise, ls_rise, lp_run;
    logic gear_tick, per_tick, pre_tick, sys_tick, new_tick;
    logic [2:0] gmask;
    logic [5:0] pmask;
    logic [4:0] wu_exp;
    localparam logic [7:0][4:0] wu_ls_exps = `CMC_WU_LS_TABLE; // Indexed by time selection

    // Oscillators stop in SLEEP (high-speed) and STOP (both)
    always_comb begin
        lp_run = (low_power_mode == `CMC_LP_RUN);
        hs_run = hs_osc_enable && (low_power_mode != `CMC_LP_SLEEP)
                 && (low_power_mode != `CMC_LP_STOP);
        ls_run = ls_osc_enable && (low_power_mode != `CMC_LP_STOP);
        hs_tick = hs_run && (hs_sync_reg[1] != hs_prev_reg);
        ls_tick = ls_run && (ls_sync_reg[1] != ls_prev_reg);
        hs_rise = hs_tick && hs_sync_reg[1];
        ls_rise = ls_tick && ls_sync_reg[1];
        // Gear divider picks every 1st, 2nd, 4th or 8th half period
        gmask = 3'((4'h1 << gear_reg) - 4'h1);
        gear_tick = hs_tick && ((gdiv_reg & gmask) == 3'h0);
        // Peripheral source: geared clock or raw high-speed clock
        per_tick = peripheral_source_select ? hs_tick : gear_tick;
        pmask = 6'((7'h01 << prescaler_divide_field) - 7'h01);
        pre_tick = per_tick && ((pdiv_reg & pmask[4:0]) == 5'h00);
        sys_tick = status_reg ? ls_tick : gear_tick;
        new_tick = system_clock_select_bit ? ls_tick : gear_tick;
    end

    // Clock path next state
    always_comb begin
        gear_next = gear_reg;
        gear_pend_next = gear_pend_reg;
        gear_dly_next = gear_dly_reg;
        gdiv_next = hs_tick ? 3'(gdiv_reg + 3'h1) : gdiv_reg;
        pdiv_next = per_tick ? 5'(pdiv_reg + 5'h01) : pdiv_reg;
        sys_clk_next = sys_clk_reg;
        sys2_next = sys2_reg;
        status_next = status_reg;
        ls_lvl_next = ls_tick ? !ls_lvl_reg : ls_lvl_reg;
        // Prescaler clock stops with the peripherals
        pre_clk_next = (pre_tick && per_en_reg) ? !pre_clk_reg : pre_clk_reg;
        // A write arms the delay; the new gear lands when it runs out
        if (gear_write) begin
            gear_pend_next = gear_field;
            gear_dly_next = `CMC_GEAR_DELAY;
        end else if (gear_dly_reg != 3'h0) begin
            gear_dly_next = 3'(gear_dly_reg - 3'h1);
            if (gear_dly_reg == 3'h1) begin
                gear_next = gear_pend_reg;
            end
        end
        // Switch only from a low phase and on the new source's edge,
        // so no high phase is ever cut short
        if (system_clock_select_bit != status_reg) begin
            if (!sys_clk_reg && new_tick) begin
                status_next = system_clock_select_bit;
                sys_clk_next = 1'b1;
                sys2_next = !sys2_reg;
            end else if (sys_clk_reg && sys_tick) begin
                sys_clk_next = 1'b0; // Old source ends its high phase first
            end
        end else if (sys_tick) begin
            sys_clk_next = !sys_clk_reg;
            if (!sys_clk_reg) begin
                sys2_next = !sys2_reg;
            end
        end
        mode_next = status_next ? cmc_pkg::CMC_SLOW : cmc_pkg::CMC_NORMAL;
    end

    // Clock path registers; reset gives NORMAL, gear 1/1, undivided
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            {hs_sync_reg, ls_sync_reg, hs_prev_reg, ls_prev_reg} <= 6'h00;
            gear_reg <= `CMC_GEAR_DIV1;
            gear_pend_reg <= `CMC_GEAR_DIV1;
            gear_dly_reg <= 3'h0;
            {gdiv_reg, pdiv_reg} <= 8'h00;
            {sys_clk_reg, sys2_reg, pre_clk_reg, ls_lvl_reg} <= 4'h0;
            status_reg <= 1'b0;
            mode_reg <= cmc_pkg::CMC_NORMAL;
        end else begin
            hs_sync_reg <= {hs_sync_reg[0], high_speed_clock};
            ls_sync_reg <= {ls_sync_reg[0], low_speed_clock};
            hs_prev_reg <= hs_sync_reg[1];
            ls_prev_reg <= ls_sync_reg[1];
            gear_reg <= gear_next;
            gear_pend_reg <= gear_pend_next;
            gear_dly_reg <= gear_dly_next;
            gdiv_reg <= gdiv_next;
            pdiv_reg <= pdiv_next;
            sys_clk_reg <= sys_clk_next;
            sys2_reg <= sys2_next;
            pre_clk_reg <= pre_clk_next;
            ls_lvl_reg <= ls_lvl_next;
            status_reg <= status_next;
            mode_reg <= mode_next;
        end
    end

    // Warm-up exponent per source; selection zero skips the count
    always_comb begin
        wu_exp = warmup_source_select ? wu_ls_exps[warmup_time_field]
                 : 5'(`CMC_WU_HS_BASE + {2'h0, warmup_time_field});
    end

    // Warm-up and output control next state
    always_comb begin
        wu_busy_next = wu_busy_reg;
        wu_cnt_next = wu_cnt_reg;
        wu_lim_next = wu_lim_reg;
        wu_src_next = wu_src_reg;
        // A start pulse wins over completion in the same cycle
        if (warmup_start_bit && (warmup_time_field != `CMC_WU_NONE)) begin
            wu_busy_next = 1'b1;
            wu_cnt_next = '0;
            wu_lim_next = cmc_pkg::cmc_wu_t'(1) << wu_exp;
            wu_src_next = warmup_source_select;
        end else if (warmup_start_bit) begin
            wu_busy_next = 1'b0;
        end else if (wu_busy_reg && (wu_src_reg ? ls_rise : hs_rise)) begin
            wu_cnt_next = cmc_pkg::cmc_wu_t'(wu_cnt_reg + 19'h00001);
            if (wu_cnt_next == wu_lim_reg) begin
                wu_busy_next = 1'b0;
            end
        end
        // Clocks other than low-speed freeze outside NORMAL and SLOW
        sco_next = sco_reg;
        case (clock_output_select)
            `CMC_SCO_LS: sco_next = ls_lvl_reg;
            `CMC_SCO_SYS2: sco_next = lp_run ? sys2_reg : sco_reg;
            `CMC_SCO_SYS: sco_next = lp_run ? sys_clk_reg : sco_reg;
            `CMC_SCO_PRE: sco_next = lp_run ? pre_clk_reg : sco_reg;
            default: sco_next = sco_reg;
        endcase
        sco_oe_next = port_k1_direction_bit && port_k1_function_bit;
        core_en_next = lp_run;
        // Peripherals run only in NORMAL and IDLE
        per_en_next = !status_next && ((low_power_mode == `CMC_LP_RUN)
                      || (low_power_mode == `CMC_LP_IDLE));
        pll_next = pll_enable_bit && per_en_next;
    end

    // Warm-up and output registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            {wu_busy_reg, wu_src_reg, sco_reg, sco_oe_reg} <= 4'h0;
            {wu_cnt_reg, wu_lim_reg} <= '0;
            {core_en_reg, per_en_reg} <= 2'h3;
            pll_reg <= 1'b0;
        end else begin
            wu_busy_reg <= wu_busy_next;
            wu_cnt_reg <= wu_cnt_next;
            wu_lim_reg <= wu_lim_next;
            wu_src_reg <= wu_src_next;
            sco_reg <= sco_next;
            sco_oe_reg <= sco_oe_next;
            core_en_reg <= core_en_next;
            per_en_reg <= per_en_next;
            pll_reg <= pll_next;
        end
    end

    // Pin carries the selected clock whatever the configuration; only the enable follows it
    assign clock_output_pin = sco_reg;
    assign clock_output_oe = sco_oe_reg;
    assign warmup_status_bit = wu_busy_reg;
    assign system_clock_status_bit = status_reg;
    assign system_clock = sys_clk_reg;
    assign prescaler_base_clock = pre_clk_reg;
    assign core_clock_enable = core_en_reg;
    assign periph_clock_enable = per_en_reg;
    assign pll_active = pll_reg;
    assign slow_mode = (mode_reg == cmc_pkg::CMC_SLOW);
    assign gear_active = gear_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_wu_start;
        warmup_start_bit && (warmup_time_field != `CMC_WU_NONE) |=> wu_busy_reg; endproperty
    a_wu_start: assert property (p_wu_start) else $error("warm-up did not start");
    property p_wu_done;
        $fell(wu_busy_reg) && !$past(warmup_start_bit) |->
            $past(wu_cnt_reg) == 19'(wu_lim_reg - 19'h00001); endproperty
    a_wu_done: assert property (p_wu_done) else $error("warm-up ended early");
    property p_sw_clean;
        $changed(status_reg) |-> !$past(sys_clk_reg) && sys_clk_reg; endproperty
    a_sw_clean: assert property (p_sw_clean) else $error("switch cut a pulse");
    property p_status_hold;
        status_reg == system_clock_select_bit |=> $stable(status_reg); endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved");
    property p_gear_lat;
        gear_write ##1 (!gear_write)[*5] |-> gear_reg == $past(gear_field, 5); endproperty
    a_gear_lat: assert property (p_gear_lat) else $error("gear not applied");
    property p_pin_oe;
        ##1 1'b1 |-> clock_output_oe == $past(port_k1_direction_bit && port_k1_function_bit);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
    property p_core_halt;
        low_power_mode != `CMC_LP_RUN |=> !core_clock_enable; endproperty
    a_core_halt: assert property (p_core_halt) else $error("core clock on");
    property p_sco_hold;
        $past(low_power_mode) != `CMC_LP_RUN && $past(clock_output_select) != `CMC_SCO_LS
            |-> $stable(sco_reg); endproperty
    a_sco_hold: assert property (p_sco_hold) else $error("output toggled");
    property p_slow_per;
        slow_mode |-> !periph_clock_enable && !pll_active; endproperty
    a_slow_per: assert property (p_slow_per) else $error("slow with periph");
    property p_reset_state;
        $rose(rstn) |-> !status_reg && gear_reg == `CMC_GEAR_DIV1 && !pll_reg; endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset");

    c_wu_end: cover property ($fell(wu_busy_reg));
    c_to_slow: cover property ($rose(status_reg));
    c_to_normal: cover property ($fell(status_reg));
    c_gear: cover property ($changed(gear_reg));
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "cmc_defs.svh"

module tb;
    // Stimulus row: pin config and mode in, enables and pin activity out
    typedef struct {logic dir, fn, pll; logic [1:0] lp; logic oe, core, pa, tog;} cmc_row_s;
    logic ref_clk = 1'b0; // 200 MHz reference clock
    logic rstn = 1'b0; // Sync reset, active low
    logic high_speed_clock = 1'b0, low_speed_clock = 1'b0; // Oscillator pins
    logic [2:0] osc_ph = 3'h0; // Divider phase for the two oscillators
    logic hs_osc_enable = 1'b1, ls_osc_enable = 1'b1, pll_enable_bit = 1'b0;
    logic warmup_source_select = 1'b0, warmup_start_bit = 1'b0, system_clock_select_bit = 1'b0;
    logic [2:0] warmup_time_field = 3'h0, prescaler_divide_field = `CMC_PRE_DIV1;
    logic [1:0] gear_field = `CMC_GEAR_DIV1, clock_output_select = `CMC_SCO_SYS;
    logic [1:0] low_power_mode = `CMC_LP_RUN, gear_active;
    logic gear_write = 1'b0, peripheral_source_select = 1'b0;
    logic port_k1_direction_bit = 1'b0, port_k1_function_bit = 1'b0;
    logic warmup_status_bit, system_clock_status_bit, system_clock, prescaler_base_clock;
    logic clock_output_pin, clock_output_oe, core_clock_enable, periph_clock_enable;
    logic pll_active, slow_mode;
    int n_fail = 0, check_count = 0; // Verdict counters
    int n_sys = 0, n_pre = 0, n_pin = 0, d_sys, d_pre, d_pin; // Toggle counts
    logic l_sys = 1'b0, l_pre = 1'b0, l_pin = 1'b0; // Last seen clock levels
    int i;
    // Ordinary cases; pin output selection is the system clock throughout
    cmc_row_s rows [8] = '{
        '{1'b1, 1'b1, 1'b1, `CMC_LP_RUN, 1'b1, 1'b1, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, `CMC_LP_RUN, 1'b0, 1'b1, 1'b0, 1'b1},
        '{1'b0, 1'b1, 1'b1, `CMC_LP_IDLE, 1'b0, 1'b0, 1'b1, 1'b0},
        '{1'b1, 1'b1, 1'b0, `CMC_LP_IDLE, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b1, `CMC_LP_SLEEP, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b0, `CMC_LP_SLEEP, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b1, `CMC_LP_STOP, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b0, `CMC_LP_STOP, 1'b0, 1'b0, 1'b0, 1'b0}};
    int sel_exp [4] = '{32, 64, 128, 128}; // Pin toggles in 256 cycles per selection

    cmc_clock_mode_ctrl dut (.ref_clk(ref_clk), .rstn(rstn),
        .high_speed_clock(high_speed_clock), .low_speed_clock(low_speed_clock),
        .hs_osc_enable(hs_osc_enable), .ls_osc_enable(ls_osc_enable),
        .pll_enable_bit(pll_enable_bit), .warmup_source_select(warmup_source_select),
        .warmup_time_field(warmup_time_field), .warmup_start_bit(warmup_start_bit),
        .system_clock_select_bit(system_clock_select_bit), .gear_field(gear_field),
        .gear_write(gear_write), .peripheral_source_select(peripheral_source_select),
        .prescaler_divide_field(prescaler_divide_field),
        .clock_output_select(clock_output_select),
        .port_k1_direction_bit(port_k1_direction_bit),
        .port_k1_function_bit(port_k1_function_bit), .low_power_mode(low_power_mode),
        .warmup_status_bit(warmup_status_bit), .system_clock_status_bit(system_clock_status_bit),
        .system_clock(system_clock), .prescaler_base_clock(prescaler_base_clock),
        .clock_output_pin(clock_output_pin), .clock_output_oe(clock_output_oe),
        .core_clock_enable(core_clock_enable), .periph_clock_enable(periph_clock_enable),
        .pll_active(pll_active), .slow_mode(slow_mode), .gear_active(gear_active));

    // Half period of 2.5 ns gives 200 MHz
    always #2.5 ref_clk = ~ref_clk;

    // High-speed pin edge every 2 cycles, low-speed every 8; both from one phase counter
    always @(posedge ref_clk) begin
        osc_ph <= osc_ph + 3'h1;
        if (osc_ph[0]) high_speed_clock <= ~high_speed_clock;
        if (osc_ph == 3'h7) low_speed_clock <= ~low_speed_clock;
    end

    // Edge counters on the produced clocks, sampled before the design updates them
    always @(posedge ref_clk) begin
        n_sys += int'(system_clock !== l_sys);
        n_pre += int'(prescaler_base_clock !== l_pre);
        n_pin += int'(clock_output_pin !== l_pin);
        l_sys = system_clock;
        l_pre = prescaler_base_clock;
        l_pin = clock_output_pin;
    end

    // Wait cycles, then step past the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Count toggles over a window
    task automatic meas(input int n);
        int a, b, c;
        a = n_sys;
        b = n_pre;
        c = n_pin;
        cyc(n);
        d_sys = n_sys - a;
        d_pre = n_pre - b;
        d_pin = n_pin - c;
    endtask

    task automatic chk_bit(input string what, input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Counts allow a few edges of slack for phase at window ends
    task automatic chk_cnt(input string what, input int exp, input int got);
        check_count++;
        if (got < exp - 3 || got > exp + 3) begin
            n_fail++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One-cycle start pulse with source and time
    task automatic start_wu(input logic src, input logic [2:0] t);
        @(posedge ref_clk);
        warmup_source_select <= src;
        warmup_time_field <= t;
        warmup_start_bit <= 1'b1;
        @(posedge ref_clk);
        warmup_start_bit <= 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Whole run is near 8000 cycles; two and a half times that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        cyc(16);
        chk_bit("status", 1'b0, system_clock_status_bit);
        chk_bit("slow", 1'b0, slow_mode);
        chk_bit("gear", `CMC_GEAR_DIV1, gear_active);
        chk_bit("pll", 1'b0, pll_active);
        chk_bit("busy", 1'b0, warmup_status_bit);
        @(posedge ref_clk);
        rstn <= 1'b1;
        cyc(10);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            port_k1_direction_bit <= rows[i].dir;
            port_k1_function_bit <= rows[i].fn;
            pll_enable_bit <= rows[i].pll;
            low_power_mode <= rows[i].lp;
            cyc(6);
            chk_bit("oe", rows[i].oe, clock_output_oe);
            chk_bit("core", rows[i].core, core_clock_enable);
            chk_bit("pll", rows[i].pa, pll_active);
            meas(40);
            chk_bit("pin toggling", rows[i].tog, d_pin > 0);
        end
        @(posedge ref_clk);
        low_power_mode <= `CMC_LP_RUN;
        peripheral_source_select <= 1'b1;
        $display("test table done");
        // Every output selection; undivided prescaler follows the raw clock
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            clock_output_select <= i[1:0];
            cyc(8);
            meas(256);
            chk_cnt("pin rate", sel_exp[i], d_pin);
        end
        // Low-speed selection keeps running in a low-power mode
        @(posedge ref_clk);
        clock_output_select <= `CMC_SCO_LS;
        low_power_mode <= `CMC_LP_IDLE;
        cyc(8);
        meas(256);
        chk_cnt("pin idle ls", 32, d_pin);
        @(posedge ref_clk);
        low_power_mode <= `CMC_LP_RUN;
        prescaler_divide_field <= 3'h2;
        cyc(8);
        meas(256);
        chk_cnt("prescaler div4", 32, d_pre);
        $display("test output select done");
        // Gear write to divide by eight: not at once, applied within the delay
        @(posedge ref_clk);
        gear_field <= 2'h3;
        gear_write <= 1'b1;
        // Geared source halved keeps the prescaler slower than the system clock
        peripheral_source_select <= 1'b0;
        prescaler_divide_field <= 3'h1;
        @(posedge ref_clk);
        gear_write <= 1'b0;
        cyc(2);
        chk_bit("gear early", `CMC_GEAR_DIV1, gear_active);
        cyc(5);
        chk_bit("gear late", 2'h3, gear_active);
        cyc(8);
        meas(256);
        chk_cnt("sys div8", 16, d_sys);
        chk_cnt("prescaler geared", 8, d_pre);
        @(posedge ref_clk);
        gear_field <= `CMC_GEAR_DIV1;
        gear_write <= 1'b1;
        @(posedge ref_clk);
        gear_write <= 1'b0;
        cyc(8);
        chk_bit("gear back", `CMC_GEAR_DIV1, gear_active);
        $display("test gear done");
        // Low-speed warm-up of 2^6 rises, then switch to SLOW
        start_wu(1'b1, 3'h1);
        cyc(1);
        chk_bit("busy start", 1'b1, warmup_status_bit);
        cyc(900);
        chk_bit("busy mid", 1'b1, warmup_status_bit);
        for (i = 0; i < 300 && warmup_status_bit !== 1'b0; i++) cyc(1);
        chk_bit("busy end", 1'b0, warmup_status_bit);
        @(posedge ref_clk);
        system_clock_select_bit <= 1'b1;
        for (i = 0; i < 100 && system_clock_status_bit !== 1'b1; i++) cyc(1);
        chk_bit("status ls", 1'b1, system_clock_status_bit);
        chk_bit("slow", 1'b1, slow_mode);
        chk_bit("periph", 1'b0, periph_clock_enable);
        chk_bit("pll slow", 1'b0, pll_active);
        @(posedge ref_clk);
        hs_osc_enable <= 1'b0;
        clock_output_select <= `CMC_SCO_SYS;
        cyc(8);
        meas(256);
        chk_cnt("sys slow", 32, d_sys);
        // Zero time: no count at all
        start_wu(1'b0, `CMC_WU_NONE);
        cyc(2);
        chk_bit("busy none", 1'b0, warmup_status_bit);
        $display("test slow done");
        // High-speed warm-up of 2^10 rises, then back to NORMAL
        @(posedge ref_clk);
        hs_osc_enable <= 1'b1;
        start_wu(1'b0, 3'h1);
        cyc(1);
        chk_bit("busy hs", 1'b1, warmup_status_bit);
        cyc(3900);
        chk_bit("busy hs mid", 1'b1, warmup_status_bit);
        for (i = 0; i < 500 && warmup_status_bit !== 1'b0; i++) cyc(1);
        chk_bit("busy hs end", 1'b0, warmup_status_bit);
        @(posedge ref_clk);
        system_clock_select_bit <= 1'b0;
        for (i = 0; i < 100 && system_clock_status_bit !== 1'b0; i++) cyc(1);
        chk_bit("status hs", 1'b0, system_clock_status_bit);
        chk_bit("normal", 1'b0, slow_mode);
        chk_bit("periph back", 1'b1, periph_clock_enable);
        @(posedge ref_clk);
        ls_osc_enable <= 1'b0;
        cyc(8);
        meas(256);
        chk_cnt("sys normal", 128, d_sys);
        $display("test normal done");
        // Mid-run reset from NORMAL with a gear and the PLL set
        @(posedge ref_clk);
        pll_enable_bit <= 1'b1;
        gear_field <= 2'h2;
        gear_write <= 1'b1;
        @(posedge ref_clk);
        gear_write <= 1'b0;
        cyc(8);
        chk_bit("gear pre reset", 2'h2, gear_active);
        // Reset only requested outside SLOW
        @(posedge ref_clk);
        rstn <= 1'b0;
        cyc(4);
        chk_bit("gear reset", `CMC_GEAR_DIV1, gear_active);
        chk_bit("pll reset", 1'b0, pll_active);
        @(posedge ref_clk);
        rstn <= 1'b1;
        cyc(2);
        chk_bit("status rerun", 1'b0, system_clock_status_bit);
        chk_bit("pll rerun", 1'b1, pll_active);
        $display("test rerun done");
        close_out();
    end
endmodule
